//--- bench/sync_cfg_properties.sv
// Checker on the sync configuration block's ports.
// Assumes zero-wait reads, with read data standing in the next cycle.
`timescale 1ns/1ps
`default_nettype none
module sync_cfg_properties
    import sync_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic sync0_event_i,
    input wire logic sm2_event_i,
    input wire logic [31:0] sync0_period_reg_i,
    input wire logic out_process_o,
    input wire logic dc_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence rd_s(logic [11:0] a);
        hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD && !hwrite_i && haddr_i == 32'(a);
    endsequence
    bus_okay_a: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not ready or not okay");
    dc_trigger_a: assert property (dc_mode_o && sync0_event_i |=> out_process_o)
        else $error("sync0 event not processed");
    sm2_trigger_a: assert property (!dc_mode_o && sm2_event_i |=> out_process_o)
        else $error("sm2 event not processed");
    no_stray_a: assert property (out_process_o |-> $past(dc_mode_o ? sync0_event_i : sm2_event_i))
        else $error("processing without its event");
    out_modes_a: assert property (rd_s(OFS_OUT_MODES) |=> hrdata_o[4:1] == 4'h3)
        else $error("output modes field wrong");
    in_modes_a: assert property (rd_s(OFS_IN_MODES) |=> hrdata_o == 32'h27)
        else $error("input modes wrong");
    sync0_dc_a: assert property (rd_s(OFS_OUT_SYNC0) ##0 dc_mode_o |=> hrdata_o == $past(sync0_period_reg_i))
        else $error("sync0 period not mirrored");
    sync0_sm2_a: assert property (rd_s(OFS_OUT_SYNC0) ##0 !dc_mode_o |=> hrdata_o == 32'h0)
        else $error("sync0 period not zero");
    in_delay_a: assert property (rd_s(OFS_IN_DELAY) |=> hrdata_o == 32'h0)
        else $error("input delay wrong");
endmodule
`default_nettype wire

//--- bench/sync_cfg_tb.sv
// Bench for the sync configuration block: registers over AHB-Lite, event timing.
// Assumes the paced event model as far side and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module sync_cfg_tb;
    import sync_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = HSIZE_WORD;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, sync0_period_reg_i, rd;
    logic hreadyout_o, hresp_o, sync0_event_i, sm2_event_i, out_process_o, in_latch_o, dc_mode_o;
    int err_total = 0;
    int check_count = 0;
    int n;
    logic [11:0] ra [16] = '{OFS_OUT_COUNT, OFS_IN_COUNT, OFS_OUT_SYNC, OFS_IN_SYNC, OFS_OUT_CYCLE, OFS_IN_CYCLE,
        OFS_OUT_MODES, OFS_IN_MODES, OFS_OUT_MINCYC, OFS_IN_MINCYC, OFS_OUT_DELAY, OFS_IN_DELAY, OFS_OUT_CALC,
        OFS_IN_CALC, OFS_OUT_SHIFT, 12'h100};
    logic [31:0] re [16] = '{32'h20, 32'h20, 32'h2, 32'h2, 32'hf4240, 32'hf4240, 32'h6, 32'h27, 32'h1e848,
        32'h1e848, 32'h0, 32'h0, 32'h61a8, 32'hafc8, 32'h0, 32'h0};
    logic [31:0] cyc [6] = '{32'h1e848, 32'h3d090, 32'h7a120, 32'hf4240, 32'h1e8480, 32'h3d0900};
    always #25 clk_i = ~clk_i;
    sync_master_model #(.PERIOD_CYC(3000)) FAR (.clk_i(clk_i), .nrst_i(nrst_i), .sync0_event_o(sync0_event_i),
        .sm2_event_o(sm2_event_i), .sync0_period_o(sync0_period_reg_i));
    sync_cfg DUT (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sync0_event_i(sync0_event_i), .sm2_event_i(sm2_event_i),
        .sync0_period_reg_i(sync0_period_reg_i), .out_process_o(out_process_o), .in_latch_o(in_latch_o),
        .dc_mode_o(dc_mode_o));
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task automatic await_ready();
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0, a};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        await_ready();
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        await_ready();
        rd = hrdata_o;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), exp, rd);
    endtask
    // Negedge sampling keeps clear of the pulse edges
    task automatic latch_gap(input logic [31:0] exp);
        n = 0;
        do begin @(negedge clk_i); n++; end while (sync0_event_i !== 1'b1 && n < 5000);
        n = 0;
        do begin @(negedge clk_i); n++; end while (in_latch_o !== 1'b1 && n < 5000);
        check("latch gap", exp, 32'(n));
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 16; i++) rdchk(ra[i], re[i]);
        $display("Test reset values done");
        foreach (cyc[i]) begin
            bus(1'b1, OFS_OUT_CYCLE, cyc[i]);
            rdchk(OFS_IN_CYCLE, cyc[i]);
        end
        bus(1'b1, OFS_OUT_CYCLE, 32'h1e849);
        rdchk(OFS_OUT_CYCLE, 32'h3d0900);
        rdchk(OFS_STATUS, 32'h3);
        rdchk(OFS_STATUS, 32'h1);
        $display("Test cycle times done");
        bus(1'b1, OFS_IN_SHIFT, 32'h3b20b8);
        rdchk(OFS_IN_SHIFT, 32'h3b20b8);
        bus(1'b1, OFS_IN_SHIFT, 32'h3b20b9);
        bus(1'b1, OFS_IN_SHIFT, 32'h3d0900);
        rdchk(OFS_IN_SHIFT, 32'h3b20b8);
        bus(1'b1, OFS_OUT_MODES, 32'h0);
        rdchk(OFS_OUT_MODES, 32'h6);
        rdchk(OFS_OUT_SYNC0, 32'h7a120);
        bus(1'b1, OFS_IN_SHIFT, 32'h0);
        latch_gap(32'h1);
        bus(1'b1, OFS_IN_SHIFT, 32'h1e848);
        latch_gap(32'h9c5);
        $display("Test input shift done");
        bus(1'b1, OFS_OUT_SYNC, 32'h1);
        bus(1'b1, OFS_OUT_SYNC, 32'h3);
        rdchk(OFS_OUT_SYNC, 32'h1);
        rdchk(OFS_OUT_SYNC0, 32'h0);
        bus(1'b1, OFS_IN_SHIFT, 32'h0);
        rdchk(OFS_IN_SHIFT, 32'h1e848);
        rdchk(OFS_STATUS, 32'h2);
        check("dc mode", 32'h0, {31'h0, dc_mode_o});
        // One full event period so an sm2 event lands in this mode
        repeat (3100) @(posedge clk_i);
        bus(1'b1, OFS_OUT_SYNC, 32'h2);
        rdchk(OFS_STATUS, 32'h1);
        check("dc mode", 32'h1, {31'h0, dc_mode_o});
        $display("Test sync modes done");
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        complete_run();
    end
endmodule
bind sync_cfg sync_cfg_properties CHK (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sync0_event_i(sync0_event_i), .sm2_event_i(sm2_event_i),
    .sync0_period_reg_i(sync0_period_reg_i), .out_process_o(out_process_o), .dc_mode_o(dc_mode_o));
`default_nettype wire

//--- bench/sync_master_model.sv
// Far-side stand-in: paced sync events and the controller's SYNC0 register.
// Assumes the bench clock; events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module sync_master_model #(
    parameter int PERIOD_CYC = 3000,
    parameter logic [31:0] SYNC0_NS = 32'h7a120
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    output logic sync0_event_o,
    output logic sm2_event_o,
    output logic [31:0] sync0_period_o
);
    int cnt_q;
    // Dedicated pacing hardware, so spacing never jitters
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= (cnt_q == PERIOD_CYC - 1) ? 0 : cnt_q + 1;
        end
    end
    assign sync0_event_o = (cnt_q == PERIOD_CYC - 1);
    // Offset from sync0 so the selected event can be told apart
    assign sm2_event_o = (cnt_q == PERIOD_CYC / 2 - 1);
    assign sync0_period_o = SYNC0_NS;
endmodule
`default_nettype wire

//--- hdl/sync_cfg.sv
// Synchronization configuration registers and event timing for the drive.
// Assumes AHB-Lite single word transfers, a one-cycle sync0/sm2 pulse input.
// Contract
// - DC mode selects output sync code 02h
// - SM2 mode selects output sync code 01h
// - Cycle time only listed six values
// - Input shift 0..3875000 ns, 125000 steps
// - Output modes bits 4-2 read 001b
// - Output modes bit 1 set
// - DC sync0 period mirrors controller register
// - Input supported modes constant 27h
// - Input cycle mirrors output cycle
// - Input count equals output count
// - Input minimum cycle mirrors output
// - Input delay mirrors output delay
// - SM2 mode aligns to frame reception
// - Slave clocks align to first slave
// - Shift moves input latch 125 us steps
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module sync_cfg (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic sync0_event_i,
    input wire logic sm2_event_i,
    input wire logic [31:0] sync0_period_reg_i,
    output logic out_process_o,
    output logic in_latch_o,
    output logic dc_mode_o
);
    import sync_cfg_pkg::*;

    bus_phase_t phase_q;
    logic [11:0] addr_q;
    logic write_q;
    logic [15:0] out_sync_q;
    logic [15:0] in_sync_q;
    logic [31:0] cycle_q;
    logic [31:0] shift_q;
    logic [31:0] delay_cnt_q;
    logic delay_run_q;
    logic refused_q;
    logic [31:0] sync0_rd;
    logic [31:0] rd_word;
    logic trigger;
    logic [31:0] shift_cycles;

    // Address phase capture; slave always ready, so zero wait states
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= PH_IDLE;
            addr_q <= 12'h000;
            write_q <= 1'b0;
        end else if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD) begin
            phase_q <= PH_DATA;
            addr_q <= haddr_i[11:0];
            write_q <= hwrite_i;
        end else if (hready_i) begin
            phase_q <= PH_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    wire logic wr_en = (phase_q == PH_DATA) && write_q;
    wire logic rd_take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD && !hwrite_i;

    // Sync mode registers; other codes are refused, free-run is not served here
    // Mode pin moves with the register so it never disagrees with the trigger
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_sync_q <= MODE_DC;
            in_sync_q <= MODE_DC;
            dc_mode_o <= 1'b1;
        end else if (wr_en && (hwdata_i[15:0] == MODE_DC || hwdata_i[15:0] == MODE_SM2)) begin
            if (addr_q == OFS_OUT_SYNC) begin
                out_sync_q <= hwdata_i[15:0];
                dc_mode_o <= (hwdata_i[15:0] == MODE_DC);
            end else if (addr_q == OFS_IN_SYNC) begin
                in_sync_q <= hwdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cycle_q <= CYCLE_RESET;
        end else if (wr_en && addr_q == OFS_OUT_CYCLE && cycle_ok(hwdata_i)) begin
            cycle_q <= hwdata_i;
        end
    end

    // Shift only writable in DC mode; SM2 keeps the previous value
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q <= 32'h0;
        end else if (wr_en && addr_q == OFS_IN_SHIFT && out_sync_q == MODE_DC && shift_ok(hwdata_i)) begin
            shift_q <= hwdata_i;
        end
    end

    // Sticky flag of a refused cycle or shift write; a status read clears it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            refused_q <= 1'b0;
        end else if (wr_en && ((addr_q == OFS_OUT_CYCLE && !cycle_ok(hwdata_i)) ||
                (addr_q == OFS_IN_SHIFT && !(out_sync_q == MODE_DC && shift_ok(hwdata_i))))) begin
            refused_q <= 1'b1;
        end else if (rd_take && haddr_i[11:0] == OFS_STATUS) begin
            // Cleared as the status word is captured, so no refused cycle or shift write goes unreported
            refused_q <= 1'b0;
        end
    end

    assign sync0_rd = (out_sync_q == MODE_DC) ? sync0_period_reg_i : 32'h0;
    assign trigger = (out_sync_q == MODE_DC) ? sync0_event_i : sm2_event_i;
    assign shift_cycles = (shift_q / SHIFT_STEP_NS) * STEP_CYCLES;

    // Decoded from the address phase so the word stands in the data phase
    always_comb begin
        rd_word = 32'h0;
        if (haddr_i[11:0] == OFS_OUT_COUNT || haddr_i[11:0] == OFS_IN_COUNT) begin
            rd_word = {24'h0, SUBOBJ_COUNT};
        end else if (haddr_i[11:0] == OFS_OUT_SYNC) begin
            rd_word = {16'h0, out_sync_q};
        end else if (haddr_i[11:0] == OFS_IN_SYNC) begin
            rd_word = {16'h0, in_sync_q};
        end else if (haddr_i[11:0] == OFS_OUT_CYCLE || haddr_i[11:0] == OFS_IN_CYCLE) begin
            rd_word = cycle_q;
        end else if (haddr_i[11:0] == OFS_OUT_SHIFT) begin
            rd_word = 32'h0;
        end else if (haddr_i[11:0] == OFS_IN_SHIFT) begin
            rd_word = shift_q;
        end else if (haddr_i[11:0] == OFS_OUT_MODES) begin
            rd_word = {16'h0, OUT_MODES};
        end else if (haddr_i[11:0] == OFS_IN_MODES) begin
            rd_word = {16'h0, IN_MODES};
        end else if (haddr_i[11:0] == OFS_OUT_MINCYC || haddr_i[11:0] == OFS_IN_MINCYC) begin
            rd_word = MIN_CYCLE;
        end else if (haddr_i[11:0] == OFS_OUT_CALC) begin
            rd_word = OUT_CALC;
        end else if (haddr_i[11:0] == OFS_IN_CALC) begin
            rd_word = IN_CALC;
        end else if (haddr_i[11:0] == OFS_OUT_DELAY || haddr_i[11:0] == OFS_IN_DELAY) begin
            rd_word = DELAY_NS;
        end else if (haddr_i[11:0] == OFS_OUT_SYNC0 || haddr_i[11:0] == OFS_IN_SYNC0) begin
            rd_word = sync0_rd;
        end else if (haddr_i[11:0] == OFS_STATUS) begin
            rd_word = {30'h0, refused_q, out_sync_q == MODE_DC};
        end
    end

    // Captured at the address phase edge and held until the next read;
    // limitation: a read right behind a write to the same word sees the old value
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_o <= 32'h0;
        end else if (rd_take) begin
            hrdata_o <= rd_word;
        end
    end

    // Processing strobe follows the selected timing event by one cycle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_process_o <= 1'b0;
        end else begin
            out_process_o <= trigger;
        end
    end

    // Input latch delayed by the shift time from the selected event
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            delay_cnt_q <= 32'h0;
            delay_run_q <= 1'b0;
            in_latch_o <= 1'b0;
        end else if (trigger) begin
            delay_cnt_q <= shift_cycles;
            delay_run_q <= (shift_cycles != 32'h0);
            in_latch_o <= (shift_cycles == 32'h0);
        end else if (delay_run_q && delay_cnt_q == 32'h1) begin
            delay_run_q <= 1'b0;
            delay_cnt_q <= 32'h0;
            in_latch_o <= 1'b1;
        end else begin
            delay_cnt_q <= delay_run_q ? delay_cnt_q - 32'h1 : 32'h0;
            in_latch_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- hdl/sync_cfg_pkg.sv
// Constants for the process-data synchronization configuration block.
// Assumes a single 20 MHz clock and an AHB-Lite register port.
package sync_cfg_pkg;
    localparam logic [11:0] OFS_OUT_COUNT = 12'h000;
    localparam logic [11:0] OFS_OUT_SYNC = 12'h004;
    localparam logic [11:0] OFS_OUT_CYCLE = 12'h008;
    localparam logic [11:0] OFS_OUT_SHIFT = 12'h00c;
    localparam logic [11:0] OFS_OUT_MODES = 12'h010;
    localparam logic [11:0] OFS_OUT_MINCYC = 12'h014;
    localparam logic [11:0] OFS_OUT_CALC = 12'h018;
    localparam logic [11:0] OFS_OUT_DELAY = 12'h01c;
    localparam logic [11:0] OFS_OUT_SYNC0 = 12'h020;
    localparam logic [11:0] OFS_IN_COUNT = 12'h040;
    localparam logic [11:0] OFS_IN_SYNC = 12'h044;
    localparam logic [11:0] OFS_IN_CYCLE = 12'h048;
    localparam logic [11:0] OFS_IN_SHIFT = 12'h04c;
    localparam logic [11:0] OFS_IN_MODES = 12'h050;
    localparam logic [11:0] OFS_IN_MINCYC = 12'h054;
    localparam logic [11:0] OFS_IN_CALC = 12'h058;
    localparam logic [11:0] OFS_IN_DELAY = 12'h05c;
    localparam logic [11:0] OFS_IN_SYNC0 = 12'h060;
    localparam logic [11:0] OFS_STATUS = 12'h080;

    localparam logic [15:0] MODE_SM2 = 16'h0001;
    localparam logic [15:0] MODE_DC = 16'h0002;
    localparam logic [7:0] SUBOBJ_COUNT = 8'h20;
    localparam logic [15:0] OUT_MODES = 16'h0006;
    localparam logic [15:0] IN_MODES = 16'h0027;
    localparam logic [31:0] MIN_CYCLE = 32'h0001e848;
    localparam logic [31:0] OUT_CALC = 32'h000061a8;
    localparam logic [31:0] IN_CALC = 32'h0000afc8;
    localparam logic [31:0] DELAY_NS = 32'h00000000;
    localparam logic [31:0] CYCLE_RESET = 32'h000f4240;

    localparam logic [31:0] CYC_125US = 32'h0001e848;
    localparam logic [31:0] CYC_250US = 32'h0003d090;
    localparam logic [31:0] CYC_500US = 32'h0007a120;
    localparam logic [31:0] CYC_1MS = 32'h000f4240;
    localparam logic [31:0] CYC_2MS = 32'h001e8480;
    localparam logic [31:0] CYC_4MS = 32'h003d0900;
    localparam logic [31:0] SHIFT_STEP_NS = 32'h0001e848;
    localparam logic [31:0] SHIFT_MAX_NS = 32'h003b20b8;
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [31:0] STEP_CYCLES = 32'(125000 / CLK_PERIOD_NS);

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic {PH_IDLE, PH_DATA} bus_phase_t;

    function automatic logic cycle_ok(input logic [31:0] v);
        cycle_ok = (v == CYC_125US) || (v == CYC_250US) || (v == CYC_500US) ||
            (v == CYC_1MS) || (v == CYC_2MS) || (v == CYC_4MS);
    endfunction

    function automatic logic shift_ok(input logic [31:0] v);
        shift_ok = (v <= SHIFT_MAX_NS) && ((v % SHIFT_STEP_NS) == 32'h0);
    endfunction
endpackage
